// *** inc/swrb_regs.svh ***
// Register layout and timing constants for the sleep/wake/reset/balance command block.
// Assumes a 200 MHz device clock; included by its bare name.
`ifndef SWRB_REGS_SVH
`define SWRB_REGS_SVH
`define BCFG_W            10
`define BCFG_RESET        10'h000
`define BCFG_MODE_LO      0
`define BCFG_MODE_HI      1
`define BCFG_WAIT_LO      2
`define BCFG_WAIT_HI      4
`define BCFG_PTR_LO       5
`define BCFG_PTR_HI       8
`define BCFG_RUN          9
`define CELL_W            12
`define CELL_RESET        12'h000
`define TST_W             4
`define TST_RESET         4'h0
`define TEMP_W            14
`define TEMP_RESET        14'h0000
`define ADDR_RESET        4'h0
`define MODE_OFF          2'h0
`define MODE_MANUAL       2'h1
`define MODE_TIMED        2'h2
`define MODE_AUTO         2'h3
`define PTR_ZERO          4'h0
`define CLK_MHZ           200
`define WAIT_US_500K      500
`define WAIT_US_250K      1000
`define WAIT_US_125K      2000
`define WAIT_US_62K       4000
`define WAKE_HZ           4000
`define WAKE_CYCLES       4
`define WAKE_HALF_CYC     (`CLK_MHZ * 1000000 / (2 * `WAKE_HZ))
`define TOP_ACK_US        1000
`define CNT_W             24
`endif

// *** inc/swrb_pkg.sv ***
// Types shared by the command block: command codes, power states, carriers.
// Constants live in swrb_regs.svh.
package swrb_pkg;
   typedef enum logic [2:0] {
      CMD_NONE     = 3'h0,
      CMD_SLEEP    = 3'h1,
      CMD_WAKE     = 3'h2,
      CMD_RESET    = 3'h3,
      CMD_BAL_EN   = 3'h4,
      CMD_BAL_INH  = 3'h5
   } cmd_code_t;

   typedef struct packed {
      logic      valid;
      cmd_code_t code;
      logic      broadcast;
   } cmd_req_t;

   typedef struct packed {
      logic ack;
      logic nak;
   } resp_t;

   // Gray order along awake -> wait -> asleep -> waking
   typedef enum logic [1:0] {
      PW_AWAKE  = 2'b00,
      PW_WAIT   = 2'b01,
      PW_ASLEEP = 2'b11,
      PW_WAKING = 2'b10
   } pwr_state_t;
endpackage : swrb_pkg

// *** hw/swrb_temp_check.sv ***
// Compares four external temperature readings against a low threshold.
// Readings and threshold are synchronous to ref_clk_i.
`timescale 1ns/10ps
`include "swrb_regs.svh"
module swrb_temp_check (
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  clk_en_i,
   input  wire logic [`TST_W-1:0]     enables_i,
   input  wire logic [4*`TEMP_W-1:0]  temps_i,
   input  wire logic [`TEMP_W-1:0]    thresh_i,
   output logic      [`TST_W-1:0]     fault_o
);
   logic [`TST_W-1:0] fault_d;
   logic [`TST_W-1:0] fault_q;

   // Fault per input only when its enable is set and value is below threshold
   always_comb begin
      for (int i = 0; i < `TST_W; i++) begin
         fault_d[i] = enables_i[i] && (temps_i[i*`TEMP_W +: `TEMP_W] < thresh_i);
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_q <= `TST_RESET;
      end else if (clk_en_i) begin
         fault_q <= fault_d;
      end
   end

   assign fault_o = fault_q;

   AST_TEMP_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && !enables_i[0]) |=> !fault_q[0])
      else $error("temperature fault raised with check disabled");
endmodule : swrb_temp_check

// *** hw/swrb_ctrl.sv ***
// Command block for one stack device: sleep, wake-up, reset and balance control.
// Summary of operation
// - Enabled temperature input below threshold raises a fault.
// - Disabled input is never compared; all four enables reset to zero.
// - Sleep command puts device to sleep; registers stay alive, but Manual and Timed FET drive stops while asleep.
// - Sleep must be broadcast; individually addressed Sleep is ignored, with NAK while awake and silently during the wait.
// - Top stack device answers ACK to a valid Sleep.
// - Sleep waits 500/1000/2000/4000 us by chain rate before sleeping.
// - Valid traffic on port 1 during wait cancels; another Sleep restarts wait.
// - No communication-fault timeout is applied to Sleep.
// - Watchdog expiry puts a device to sleep when the watchdog is enabled.
// - Wake-up must be broadcast; individually addressed Wake-up gets NAK at master.
// - Wake-up wakes master, which sends 4 kHz wake bursts upward; others forward.
// - Port 1 traffic is discarded while sending wake signal on port 2.
// - Top device waits after waking before sending ACK.
// - Stack wake-to-ACK is at most 63 ms for 8 and 100 ms for 14 devices.
// - No comm-fault checks while waking; host times out a missing ACK.
// - Reset restores power-up register values and clears stack address and size.
// - Broadcast Reset has no effect and Reset never answers.
// - Balance Enable sets run bit, starts balancing, accepted broadcast.
// - Balance Inhibit clears run bit, stops balancing, accepted broadcast.
// - Mode select bits 1:0 choose mode; zero means balancing off.
// - Timed mode turns all FET outputs off when duration elapses.
// - Twelve independent balance FET outputs, one per cell.
// - Mode 01 Manual, 10 Timed, 11 Auto.
// - Manual and Timed need pointer zero; cell bits select cells directly.
// - Cell bit 0 drives cell 1 FET, bit 11 cell 12; 1 enables.
// Assumes decoded commands and register writes arrive synchronous to ref_clk_i.
`timescale 1ns/10ps
`include "swrb_regs.svh"
module swrb_ctrl (
   input  wire logic                     ref_clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     clk_en_i,
   input  wire swrb_pkg::cmd_req_t       cmd_i,
   input  wire logic                     port1_valid_i,
   input  wire logic                     is_top_i,
   input  wire logic                     is_master_i,
   input  wire logic [1:0]               chain_rate_i,
   input  wire logic                     wdog_en_i,
   input  wire logic                     wdog_expired_i,
   input  wire logic                     wake_sig_in_i,
   input  wire logic                     timed_done_i,
   input  wire logic                     bcfg_we_i,
   input  wire logic [`BCFG_W-1:0]       bcfg_wdata_i,
   input  wire logic                     cell_we_i,
   input  wire logic [`CELL_W-1:0]       cell_wdata_i,
   input  wire logic                     tst_we_i,
   input  wire logic [`TST_W-1:0]        tst_wdata_i,
   input  wire logic                     addr_we_i,
   input  wire logic [7:0]               addr_wdata_i,
   input  wire logic [4*`TEMP_W-1:0]     temps_i,
   input  wire logic [`TEMP_W-1:0]       temp_thresh_i,
   output swrb_pkg::resp_t               resp_o,
   output logic                          asleep_o,
   output logic                          wake_sig_out_o,
   output logic                          port1_accept_o,
   output logic [`BCFG_W-1:0]            bcfg_o,
   output logic [`CELL_W-1:0]            cell_o,
   output logic [`TST_W-1:0]             tst_o,
   output logic [7:0]                    stack_info_o,
   output logic [`CELL_W-1:0]            balance_fet_drive_o,
   output logic [`TST_W-1:0]             temp_fault_o
);
   import swrb_pkg::*;

   // Sleep wait in cycles for a rate code; even the longest time fits the counter
   function automatic logic [`CNT_W-1:0] sleep_wait_cycles(input logic [1:0] rate);
      case (rate)
         2'h0:    sleep_wait_cycles = `CNT_W'(`WAIT_US_500K * `CLK_MHZ);
         2'h1:    sleep_wait_cycles = `CNT_W'(`WAIT_US_250K * `CLK_MHZ);
         2'h2:    sleep_wait_cycles = `CNT_W'(`WAIT_US_125K * `CLK_MHZ);
         default: sleep_wait_cycles = `CNT_W'(`WAIT_US_62K * `CLK_MHZ);
      endcase
   endfunction : sleep_wait_cycles

   localparam logic [`CNT_W-1:0] WAKE_HALF = `CNT_W'(`WAKE_HALF_CYC);
   localparam logic [`CNT_W-1:0] ACK_WAIT  = `CNT_W'(`TOP_ACK_US * `CLK_MHZ);
   localparam logic [3:0]        WAKE_EDGES = 4'(2 * `WAKE_CYCLES);

   // ---------------- register state ----------------
   logic [`BCFG_W-1:0] bcfg_q, bcfg_d;
   logic [`CELL_W-1:0] cell_q, cell_d;
   logic [`TST_W-1:0]  tst_q, tst_d;
   logic [7:0]         stack_q, stack_d;
   logic               soft_reset;

   // Individual Reset clears every register; broadcast Reset is dropped
   assign soft_reset = cmd_i.valid && (cmd_i.code == CMD_RESET) && !cmd_i.broadcast;

   // Register next values; commands override same-cycle writes of the run bit
   always_comb begin
      bcfg_d  = bcfg_q;
      cell_d  = cell_q;
      tst_d   = tst_q;
      stack_d = stack_q;
      if (bcfg_we_i) bcfg_d = bcfg_wdata_i;
      if (cell_we_i) cell_d = cell_wdata_i;
      if (tst_we_i)  tst_d  = tst_wdata_i;
      if (addr_we_i) stack_d = addr_wdata_i;
      // Timed expiry drops the run bit; a same-cycle command still wins over it
      if (bcfg_q[`BCFG_MODE_HI:`BCFG_MODE_LO] == `MODE_TIMED && timed_done_i) begin
         bcfg_d[`BCFG_RUN] = 1'b0;
      end
      if (cmd_i.valid && cmd_i.code == CMD_BAL_EN)  bcfg_d[`BCFG_RUN] = 1'b1;
      if (cmd_i.valid && cmd_i.code == CMD_BAL_INH) bcfg_d[`BCFG_RUN] = 1'b0;
      if (soft_reset) begin
         bcfg_d  = `BCFG_RESET;
         cell_d  = `CELL_RESET;
         tst_d   = `TST_RESET;
         stack_d = {`ADDR_RESET, `ADDR_RESET};
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bcfg_q  <= `BCFG_RESET;
         cell_q  <= `CELL_RESET;
         tst_q   <= `TST_RESET;
         stack_q <= {`ADDR_RESET, `ADDR_RESET};
      end else if (clk_en_i) begin
         bcfg_q  <= bcfg_d;
         cell_q  <= cell_d;
         tst_q   <= tst_d;
         stack_q <= stack_d;
      end
   end

   // ---------------- power sequencing ----------------
   pwr_state_t         pw_q, pw_d;
   logic [`CNT_W-1:0]  cnt_q, cnt_d;
   logic [3:0]         edges_q, edges_d;
   logic               wsig_q, wsig_d;
   logic               ackw_q, ackw_d;
   resp_t              resp_q, resp_d;
   logic               asleep_q, asleep_d;
   logic               accept_q, accept_d;
   logic               sleep_cmd, wake_cmd;

   assign sleep_cmd = cmd_i.valid && cmd_i.code == CMD_SLEEP;
   assign wake_cmd  = cmd_i.valid && cmd_i.code == CMD_WAKE;

   // Sleep entry, cancel, wake burst and delayed top ACK.
   // No comm-fault timer runs here at all, so a lost Sleep simply goes unanswered.
   always_comb begin
      pw_d    = pw_q;
      cnt_d   = cnt_q;
      edges_d = edges_q;
      wsig_d  = wsig_q;
      ackw_d  = ackw_q;
      resp_d  = '0;
      case (pw_q)
         PW_AWAKE: begin
            if (sleep_cmd && !cmd_i.broadcast) begin
               resp_d.nak = 1'b1;
            end else if (sleep_cmd) begin
               resp_d.ack = is_top_i;
               pw_d  = PW_WAIT;
               cnt_d = sleep_wait_cycles(chain_rate_i);
            end else if (wdog_en_i && wdog_expired_i) begin
               pw_d = PW_ASLEEP;
            end
         end
         PW_WAIT: begin
            if (sleep_cmd && cmd_i.broadcast) begin
               cnt_d = sleep_wait_cycles(chain_rate_i);
               resp_d.ack = is_top_i;
            end else if (port1_valid_i) begin
               pw_d = PW_AWAKE;
            end else if (cnt_q == '0) begin
               pw_d = PW_ASLEEP;
            end else begin
               cnt_d = cnt_q - 1'b1;
            end
         end
         PW_ASLEEP: begin
            if (wake_cmd && is_master_i && !cmd_i.broadcast) begin
               resp_d.nak = 1'b1;
            end else if ((wake_cmd && is_master_i) || wake_sig_in_i) begin
               pw_d    = PW_WAKING;
               cnt_d   = WAKE_HALF;
               edges_d = WAKE_EDGES;
               wsig_d  = 1'b1;
               ackw_d  = is_top_i;
            end
         end
         PW_WAKING: begin
            // Burst of 4 kHz cycles on port 2; no fault checks meanwhile
            if (edges_q != '0) begin
               if (cnt_q == '0) begin
                  cnt_d   = WAKE_HALF;
                  edges_d = edges_q - 1'b1;
                  wsig_d  = (edges_q != 4'h1) && !wsig_q;
                  if (edges_q == 4'h1 && ackw_q) cnt_d = ACK_WAIT;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end else if (ackw_q) begin
               // Top device holds off ACK so late-starting wake signals settle
               if (cnt_q == '0) begin
                  resp_d.ack = 1'b1;
                  ackw_d = 1'b0;
                  pw_d   = PW_AWAKE;
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end else begin
               pw_d = PW_AWAKE;
            end
         end
         default: pw_d = PW_AWAKE;
      endcase
      if (soft_reset) begin
         pw_d    = PW_AWAKE;
         wsig_d  = 1'b0;
         edges_d = '0;
         ackw_d  = 1'b0;
         resp_d  = '0;
      end
      // Status outputs follow the next state so they leave a flop with no extra lag
      asleep_d = (pw_d == PW_ASLEEP);
      accept_d = !(pw_d == PW_WAKING && edges_d != '0);
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pw_q    <= PW_AWAKE;
         cnt_q   <= '0;
         edges_q <= '0;
         wsig_q  <= 1'b0;
         ackw_q  <= 1'b0;
         resp_q  <= '0;
         asleep_q <= 1'b0;
         accept_q <= 1'b1;
      end else if (clk_en_i) begin
         pw_q    <= pw_d;
         cnt_q   <= cnt_d;
         edges_q <= edges_d;
         wsig_q  <= wsig_d;
         ackw_q  <= ackw_d;
         resp_q  <= resp_d;
         asleep_q <= asleep_d;
         accept_q <= accept_d;
      end
   end

   // ---------------- balance FET drive ----------------
   logic [`CELL_W-1:0] fet_q, fet_d;
   logic [1:0]         mode;
   logic               ptr_ok;

   assign mode   = bcfg_q[`BCFG_MODE_HI:`BCFG_MODE_LO];
   assign ptr_ok = bcfg_q[`BCFG_PTR_HI:`BCFG_PTR_LO] == `PTR_ZERO;

   // Auto sequencing lives elsewhere; here Auto drives nothing.
   // Asleep drops manual drive; timed drive is also stopped while asleep.
   always_comb begin
      fet_d = '0;
      if (bcfg_q[`BCFG_RUN] && pw_q != PW_ASLEEP && ptr_ok &&
          (mode == `MODE_MANUAL || mode == `MODE_TIMED)) begin
         fet_d = cell_q;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fet_q <= `CELL_RESET;
      end else if (clk_en_i) begin
         fet_q <= fet_d;
      end
   end

   swrb_temp_check u_temp (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .clk_en_i  (clk_en_i),
      .enables_i (tst_q),
      .temps_i   (temps_i),
      .thresh_i  (temp_thresh_i),
      .fault_o   (temp_fault_o)
   );

   assign resp_o              = resp_q;
   assign asleep_o            = asleep_q;
   assign wake_sig_out_o      = wsig_q;
   assign port1_accept_o      = accept_q;
   assign bcfg_o              = bcfg_q;
   assign cell_o              = cell_q;
   assign tst_o               = tst_q;
   assign stack_info_o        = stack_q;
   assign balance_fet_drive_o = fet_q;

   AST_SLEEP_NAK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && pw_q == PW_AWAKE && sleep_cmd && !cmd_i.broadcast && !soft_reset)
      |=> (resp_q.nak && pw_q == PW_AWAKE))
      else $error("addressed sleep not refused");
   AST_SLEEP_ENTER: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && pw_q == PW_AWAKE && sleep_cmd && cmd_i.broadcast && !soft_reset)
      |=> pw_q == PW_WAIT)
      else $error("broadcast sleep did not start wait");
   AST_CANCEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && pw_q == PW_WAIT && port1_valid_i && !sleep_cmd && !soft_reset)
      |=> pw_q == PW_AWAKE)
      else $error("port 1 traffic did not cancel sleep");
   AST_WDOG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && pw_q == PW_AWAKE && !sleep_cmd && wdog_en_i && wdog_expired_i && !soft_reset)
      |=> asleep_o)
      else $error("watchdog expiry did not sleep");
   AST_RUN_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && cmd_i.valid && cmd_i.code == CMD_BAL_EN) |=> bcfg_q[`BCFG_RUN])
      else $error("balance enable did not set run bit");
   AST_RUN_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && cmd_i.valid && cmd_i.code == CMD_BAL_INH) |=> !bcfg_q[`BCFG_RUN])
      else $error("balance inhibit did not clear run bit");
   AST_MODE_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && mode == `MODE_OFF) |=> (fet_q == '0))
      else $error("FETs on with mode off");
   AST_RESET_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      (clk_en_i && soft_reset) |=> (stack_q == '0 && bcfg_q == '0 && tst_q == '0))
      else $error("reset command left registers set");
   AST_DISCARD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      wsig_q |-> !port1_accept_o)
      else $error("port 1 accepted during wake burst");
endmodule : swrb_ctrl

// *** bench/swrb_host_model.sv ***
// Stand-in for the host and the lower neighbour: decoded commands and port 1 traffic.
// Assumes the device clock; everything changes on its falling edge.
`timescale 1ns/10ps
module swrb_host_model (
   input  wire logic          ref_clk_i,
   output swrb_pkg::cmd_req_t cmd_o,
   output logic               port1_valid_o,
   output logic               wake_sig_o
);
   import swrb_pkg::*;

   // Idle link; the neighbour below stays asleep and never starts a wake burst
   initial begin
      cmd_o         = '0;
      port1_valid_o = 1'b0;
      wake_sig_o    = 1'b0;
   end

   // One-cycle command; scenarios may pick individual addressing to provoke a refusal
   task automatic send(input cmd_code_t code, input logic bcast);
      @(negedge ref_clk_i);
      cmd_o <= '{valid: 1'b1, code: code, broadcast: bcast};
      @(negedge ref_clk_i);
      cmd_o <= '0;
   endtask : send

   // One valid frame seen on port 1
   task automatic traffic();
      @(negedge ref_clk_i);
      port1_valid_o <= 1'b1;
      @(negedge ref_clk_i);
      port1_valid_o <= 1'b0;
   endtask : traffic
endmodule : swrb_host_model

// *** bench/testbench.sv ***
// Self-checking bench for the command block: notes go in a queue, a monitor compares.
// Assumes swrb_pkg is compiled first; the full sleep wait is too long, so cancel is shown by port 1 traffic mid-wait and sleep is reached via the watchdog path.
`timescale 1ns/10ps
`include "swrb_regs.svh"
module testbench;
   import swrb_pkg::*;
   typedef struct { int kind; logic [11:0] exp; } note_t;

   logic                   ref_clk_i, rst_i, is_top_i, wdog_en_i, wdog_exp, timed_done, clk_en;
   logic [3:0]             we;
   logic [11:0]            wd;
   logic [4*`TEMP_W-1:0]   temps;
   logic [`TEMP_W-1:0]     thresh;
   cmd_req_t               cmd;
   logic                   p1_valid, wake_in;
   resp_t                  resp_o;
   logic                   asleep_o, wake_out, p1_accept;
   logic [`BCFG_W-1:0]     bcfg_o;
   logic [`CELL_W-1:0]     cell_o, fet_o;
   logic [`TST_W-1:0]      tst_o, fault_o;
   logic [7:0]             stack_o;
   logic [31:0]            rng = 32'h98b2;
   note_t                  note_q[$];
   int                     fails = 0, checked = 0;
   event                   chk_ev;
   logic [11:0]            cv, ev;
   logic [3:0]             tv, fx;

   swrb_host_model i_host (.ref_clk_i(ref_clk_i), .cmd_o(cmd), .port1_valid_o(p1_valid), .wake_sig_o(wake_in));

   swrb_ctrl i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .cmd_i(cmd),
      .port1_valid_i(p1_valid), .is_top_i(is_top_i), .is_master_i(1'b1), .chain_rate_i(2'h0),
      .wdog_en_i(wdog_en_i), .wdog_expired_i(wdog_exp), .wake_sig_in_i(wake_in),
      .timed_done_i(timed_done), .bcfg_we_i(we[0]), .bcfg_wdata_i(wd[9:0]), .cell_we_i(we[1]),
      .cell_wdata_i(wd), .tst_we_i(we[2]), .tst_wdata_i(wd[3:0]), .addr_we_i(we[3]),
      .addr_wdata_i(wd[7:0]), .temps_i(temps), .temp_thresh_i(thresh), .resp_o(resp_o),
      .asleep_o(asleep_o), .wake_sig_out_o(wake_out), .port1_accept_o(p1_accept), .bcfg_o(bcfg_o),
      .cell_o(cell_o), .tst_o(tst_o), .stack_info_o(stack_o), .balance_fet_drive_o(fet_o),
      .temp_fault_o(fault_o));

   // 200 MHz device clock
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : rnd

   // Level outputs by kind: 2 fet, 3 cfg, 4 cell, 5 enables, 6 stack, 7 fault, 8 asleep, 9 wake, 10 accept
   function automatic logic [11:0] lvl(input int k);
      case (k)
         2: lvl = fet_o;
         3: lvl = {2'h0, bcfg_o};
         4: lvl = cell_o;
         5: lvl = {8'h00, tst_o};
         6: lvl = {4'h0, stack_o};
         7: lvl = {8'h00, fault_o};
         8: lvl = {11'h000, asleep_o};
         9: lvl = {11'h000, wake_out};
         default: lvl = {11'h000, p1_accept};
      endcase
   endfunction : lvl

   task automatic fail_msg(input string m);
      fails++;
      $display("Error at %0t: %s", $time, m);
   endtask : fail_msg

   task automatic cmp_resp(input logic [1:0] e, input logic [1:0] a);
      checked++;
      if (a !== e) fail_msg($sformatf("response %b, expected %b", a, e));
   endtask : cmp_resp

   task automatic cmp_lvl(input int k, input logic [11:0] e, input logic [11:0] a);
      checked++;
      if (a !== e) fail_msg($sformatf("output kind %0d is %h, expected %h", k, a, e));
   endtask : cmp_lvl

   task automatic pop(output note_t n);
      if (note_q.size() == 0) begin
         fail_msg("result with no expectation");
         n = '{-1, 12'h000};
      end else begin
         n = note_q.pop_front();
      end
   endtask : pop

   // Monitor: every response pulse and every level sample consumes the oldest note
   always @(negedge ref_clk_i) begin
      note_t n;
      if ((resp_o.ack | resp_o.nak) === 1'b1) begin
         pop(n);
         cmp_resp(n.exp[1:0], {resp_o.ack, resp_o.nak});
      end
   end
   // Several notes may be posted in one time step, so drain every level note at the head
   always @(chk_ev) begin
      note_t n;
      while (note_q.size() > 0 && note_q[0].kind > 0) begin
         pop(n);
         cmp_lvl(n.kind, n.exp, lvl(n.kind));
      end
   end

   task automatic exp_lvl(input int k, input logic [11:0] v);
      note_q.push_back('{k, v});
      -> chk_ev;
   endtask : exp_lvl

   task automatic exp_resp(input logic [1:0] v);
      note_q.push_back('{0, {10'h000, v}});
   endtask : exp_resp

   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : idle

   // Register write: 0 cfg, 1 cell, 2 enables, 3 stack info
   task automatic wr(input int sel, input logic [11:0] d);
      @(negedge ref_clk_i);
      wd = d;
      we = 4'h1 << sel;
      @(negedge ref_clk_i);
      we = 4'h0;
      idle(3);
   endtask : wr

   task automatic end_sim();
      if (note_q.size() != 0) fail_msg("expected result never appeared");
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   // About 10000 cycles; the tests need under 2000, as no full sleep wait is run
   initial begin
      #50000;
      fail_msg("watchdog limit reached");
      end_sim();
   end

   initial begin
      {rst_i, is_top_i, wdog_en_i, wdog_exp, timed_done, we, wd, temps, thresh} = '1;
      {is_top_i, wdog_en_i, wdog_exp, timed_done, we, wd} = '0;
      clk_en = 1'b1;
      repeat (8) @(posedge ref_clk_i);
      @(negedge ref_clk_i) rst_i = 1'b0;
      exp_lvl(3, 12'h000);
      exp_lvl(5, 12'h000);
      exp_lvl(2, 12'h000);
      $display("Test reset_values done");
      // Every mode value; Timed ends by duration, the others by Inhibit
      for (int m = 0; m < 4; m++) begin
         cv = 12'(rnd()) | 12'h001;
         wr(1, cv);
         wr(0, {3'h0, `PTR_ZERO, 3'h0, m[1:0]});
         i_host.send(CMD_BAL_EN, 1'b1);
         idle(4);
         exp_lvl(3, {2'h0, 1'b1, `PTR_ZERO, 3'h0, m[1:0]});
         exp_lvl(2, (m == 1 || m == 2) ? cv : 12'h000);
         if (m == 2) begin
            @(negedge ref_clk_i) timed_done = 1'b1;
            @(negedge ref_clk_i) timed_done = 1'b0;
         end else begin
            i_host.send(CMD_BAL_INH, 1'b1);
         end
         idle(4);
         exp_lvl(3, {2'h0, 1'b0, `PTR_ZERO, 3'h0, m[1:0]});
         exp_lvl(2, 12'h000);
      end
      wr(0, {3'h1, 4'h3, 3'h0, `MODE_MANUAL});
      exp_lvl(3, {2'h0, 1'b1, 4'h3, 3'h0, `MODE_MANUAL});
      exp_lvl(2, 12'h000);
      // Clock enable low freezes every register, so a write is lost
      clk_en = 1'b0;
      wr(1, ~cv);
      exp_lvl(4, cv);
      clk_en = 1'b1;
      $display("Test balance done");
      for (int k = 0; k < 8; k++) begin
         tv = 4'(rnd());
         thresh = 14'(rnd());
         temps = 56'({rnd(), rnd()});
         wr(2, {8'h00, tv});
         for (int n = 0; n < 4; n++) fx[n] = tv[n] & (temps[n*`TEMP_W +: `TEMP_W] < thresh);
         exp_lvl(5, {8'h00, tv});
         exp_lvl(7, {8'h00, fx});
      end
      $display("Test temperature done");
      cv = 12'(rnd());
      ev = 12'(rnd());
      wr(1, cv);
      wr(3, ev);
      i_host.send(CMD_RESET, 1'b1);
      idle(4);
      exp_lvl(4, cv);
      exp_lvl(6, {4'h0, ev[7:0]});
      i_host.send(CMD_RESET, 1'b0);
      idle(4);
      exp_lvl(4, 12'h000);
      exp_lvl(6, 12'h000);
      exp_lvl(5, 12'h000);
      exp_lvl(3, 12'h000);
      $display("Test reset_command done");
      exp_resp(2'b01);
      i_host.send(CMD_SLEEP, 1'b0);
      is_top_i = 1'b1;
      exp_resp(2'b10);
      i_host.send(CMD_SLEEP, 1'b1);
      idle(1000);
      i_host.traffic();
      idle(4);
      exp_lvl(8, 12'h000);
      $display("Test sleep_cancel done");
      @(negedge ref_clk_i) wdog_exp = 1'b1;
      idle(4);
      exp_lvl(8, 12'h000);
      wdog_en_i = 1'b1;
      idle(4);
      exp_lvl(8, 12'h001);
      wdog_exp = 1'b0;
      exp_resp(2'b01);
      i_host.send(CMD_WAKE, 1'b0);
      i_host.send(CMD_WAKE, 1'b1);
      idle(4);
      exp_lvl(9, 12'h001);
      exp_lvl(10, 12'h000);
      @(negedge ref_clk_i) rst_i = 1'b1;
      @(negedge ref_clk_i) rst_i = 1'b0;
      idle(2);
      exp_lvl(10, 12'h001);
      exp_lvl(8, 12'h000);
      $display("Test watchdog_wake done");
      idle(4);
      end_sim();
   end
endmodule : testbench
